// ===== acc_cfg.svh
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH
`define ACC_W 32
`define WORD_W 16
`define ADDR_W 16
`define STACK_DEPTH 8
`define BIT_ADDR_W 11
`define ACC_RST 32'h0000_0000
`endif

// ===== acc_pkg.sv
`include "acc_cfg.svh"
package acc_pkg;
  typedef enum logic [3:0] {
    op_none,
    op_load,
    op_load_double,
    op_pop,
    op_store_indexed,
    op_store_low_byte,
    op_store_high_byte,
    op_and_word,
    op_and_double_word,
    op_and_double_const,
    op_and_bit_field,
    op_and_stack
  } op_t;

  typedef struct packed {
    op_t op;
    logic [`ADDR_W-1:0] addr;
    logic [`ACC_W-1:0] imm;
    logic [5:0] bit_count;
  } cmd_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [`ADDR_W-1:0] addr;
    logic [`WORD_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic re;
    logic [`BIT_ADDR_W-1:0] addr;
    logic [5:0] count;
  } bit_req_t;
endpackage

// ===== accumulator_stack_logic_ops.sv
`include "acc_cfg.svh"
module accumulator_stack_logic_ops
  import acc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input acc_pkg::cmd_t cmd,
  output logic cmd_ready,
  output logic done,
  output acc_pkg::mem_req_t mem_req,
  input wire logic [`WORD_W-1:0] mem_rdata,
  output acc_pkg::bit_req_t bit_req,
  input wire logic [`ACC_W-1:0] bit_rdata,
  output logic [`ACC_W-1:0] acc,
  output logic zero_result_flag,
  output logic negative_result_flag
);
  import acc_pkg::*;

  typedef enum logic [2:0] {
    st_idle, st_rd0, st_rd1, st_rd2, st_wr, st_done
  } state_t;

  state_t state_r, state_nxt;
  cmd_t cmd_r, cmd_nxt;
  logic [`ACC_W-1:0] acc_r, acc_nxt;
  logic [`ACC_W-1:0] stk_r [`STACK_DEPTH];
  logic [`ACC_W-1:0] stk_nxt [`STACK_DEPTH];
  logic [`WORD_W-1:0] lo_r, lo_nxt;
  logic zf_r, zf_nxt, nf_r, nf_nxt;
  logic last_load_r, last_load_nxt;
  mem_req_t mem_r, mem_nxt;
  bit_req_t bit_r, bit_nxt;
  logic done_r, done_nxt;
  logic ready_r, ready_nxt;

  function automatic logic [`ACC_W-1:0] field_mask(input logic [5:0] n);
    logic [`ACC_W-1:0] m;
    m = '1;
    if (n < 6'h20)
      m = ~({`ACC_W{1'b1}} << n);
    return m;
  endfunction

  function automatic logic is_load(input op_t o);
    return (o == op_load) || (o == op_load_double);
  endfunction

  always_comb
  begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    acc_nxt = acc_r;
    stk_nxt = stk_r;
    lo_nxt = lo_r;
    zf_nxt = zf_r;
    nf_nxt = nf_r;
    last_load_nxt = last_load_r;
    mem_nxt = '0;
    bit_nxt = '0;
    done_nxt = 1'b0;
    case (state_r)
      st_idle:
        if (cmd_valid)
        begin
          cmd_nxt = cmd;
          last_load_nxt = is_load(cmd.op);
          case (cmd.op)
            op_load, op_load_double:
            begin
              if (last_load_r)
              begin
                for (int i = `STACK_DEPTH-1; i > 0; i--)
                  stk_nxt[i] = stk_r[i-1];
                stk_nxt[0] = acc_r;
              end
              mem_nxt.re = 1'b1;
              mem_nxt.addr = cmd.addr;
              state_nxt = st_rd0;
            end
            op_pop:
            begin
              acc_nxt = stk_r[0];
              for (int i = 0; i < `STACK_DEPTH-1; i++)
                stk_nxt[i] = stk_r[i+1];
              stk_nxt[`STACK_DEPTH-1] = '0;
              zf_nxt = (stk_r[0] == '0);
              state_nxt = st_done;
            end
            op_store_indexed:
            begin
              mem_nxt.we = 1'b1;
              // binary offset, no octal or bcd fixup
              mem_nxt.addr = cmd.addr + acc_r[`ADDR_W-1:0];
              mem_nxt.wdata = stk_r[0][`WORD_W-1:0];
              acc_nxt = {16'h0000, acc_r[15:0]};
              state_nxt = st_done;
            end
            op_store_low_byte, op_store_high_byte, op_and_word,
            op_and_double_word:
            begin
              mem_nxt.re = 1'b1;
              mem_nxt.addr = cmd.addr;
              state_nxt = st_rd0;
            end
            op_and_double_const:
            begin
              acc_nxt = acc_r & cmd.imm;
              zf_nxt = (acc_nxt == '0);
              nf_nxt = acc_nxt[31];
              state_nxt = st_done;
            end
            op_and_bit_field:
            begin
              bit_nxt.re = 1'b1;
              bit_nxt.addr = cmd.addr[`BIT_ADDR_W-1:0];
              bit_nxt.count = cmd.bit_count;
              state_nxt = st_rd0;
            end
            op_and_stack:
            begin
              acc_nxt = acc_r & stk_r[0];
              for (int i = 0; i < `STACK_DEPTH-1; i++)
                stk_nxt[i] = stk_r[i+1];
              stk_nxt[`STACK_DEPTH-1] = '0;
              zf_nxt = (acc_nxt == '0);
              nf_nxt = acc_nxt[31];
              state_nxt = st_done;
            end
            default:
              state_nxt = st_done;
          endcase
        end
      st_rd0:
        state_nxt = st_rd1; // request seen by memory this cycle
      st_rd1:
        case (cmd_r.op)
          op_load:
          begin
            acc_nxt = {16'h0000, mem_rdata};
            state_nxt = st_done;
          end
          op_store_low_byte:
          begin
            mem_nxt.we = 1'b1;
            mem_nxt.addr = cmd_r.addr;
            mem_nxt.wdata = {mem_rdata[15:8], acc_r[7:0]};
            state_nxt = st_wr;
          end
          op_store_high_byte:
          begin
            mem_nxt.we = 1'b1;
            mem_nxt.addr = cmd_r.addr;
            mem_nxt.wdata = {acc_r[15:8], mem_rdata[7:0]};
            state_nxt = st_wr;
          end
          op_and_word:
          begin
            acc_nxt = {16'h0000, acc_r[15:0] & mem_rdata};
            zf_nxt = (acc_nxt == '0);
            nf_nxt = (acc_nxt == '0);
            state_nxt = st_done;
          end
          op_and_bit_field:
          begin
            acc_nxt = acc_r & bit_rdata
              & field_mask(cmd_r.bit_count);
            zf_nxt = (acc_nxt == '0);
            nf_nxt = acc_nxt[31];
            state_nxt = st_done;
          end
          default:
          begin
            // low word of a double read; fetch the high word next
            lo_nxt = mem_rdata;
            mem_nxt.re = 1'b1;
            mem_nxt.addr = cmd_r.addr + 16'h0001;
            state_nxt = st_rd2;
          end
        endcase
      st_rd2:
        state_nxt = st_wr;
      st_wr:
      begin
        if (cmd_r.op == op_load_double)
          acc_nxt = {mem_rdata, lo_r};
        else if (cmd_r.op == op_and_double_word)
        begin
          acc_nxt = acc_r & {mem_rdata, lo_r};
          zf_nxt = (acc_nxt == '0);
          nf_nxt = acc_nxt[31];
        end
        state_nxt = st_done;
      end
      default:
      begin
        done_nxt = 1'b1;
        state_nxt = st_idle;
      end
    endcase
    ready_nxt = (state_nxt == st_idle);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= st_idle;
      cmd_r <= '0;
      acc_r <= `ACC_RST;
      for (int i = 0; i < `STACK_DEPTH; i++)
        stk_r[i] <= '0;
      lo_r <= '0;
      zf_r <= 1'b0;
      nf_r <= 1'b0;
      last_load_r <= 1'b0;
      mem_r <= '0;
      bit_r <= '0;
      done_r <= 1'b0;
      ready_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      acc_r <= acc_nxt;
      stk_r <= stk_nxt;
      lo_r <= lo_nxt;
      zf_r <= zf_nxt;
      nf_r <= nf_nxt;
      last_load_r <= last_load_nxt;
      mem_r <= mem_nxt;
      bit_r <= bit_nxt;
      done_r <= done_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign cmd_ready = ready_r;
  assign done = done_r;
  assign mem_req = mem_r;
  assign bit_req = bit_r;
  assign acc = acc_r;
  assign zero_result_flag = zf_r;
  assign negative_result_flag = nf_r;

  logic go;
  assign go = cmd_valid && state_r == st_idle;

  chk_pop_moves: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    go && cmd.op == op_pop |=> acc_r == $past(stk_r[0])
      && stk_r[0] == $past(stk_r[1]))
    else $error("pop wrong");
  chk_pop_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    go && cmd.op == op_pop |=> zf_r == (acc_r == '0))
    else $error("pop zero flag wrong");
  chk_load_push: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    go && is_load(cmd.op) && last_load_r |=> stk_r[0] == $past(acc_r))
    else $error("load push wrong");
  chk_idx_store: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    go && cmd.op == op_store_indexed |=> mem_r.we
      && mem_r.addr == $past(cmd.addr + acc_r[15:0])
      && mem_r.wdata == $past(stk_r[0][15:0])
      && acc_r[31:16] == 16'h0000)
    else $error("indexed store wrong");
  chk_low_keep: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    state_r == st_rd1 && cmd_r.op == op_store_low_byte |=>
      mem_r.wdata == {$past(mem_rdata[15:8]), acc_r[7:0]})
    else $error("low byte store wrong");
  chk_high_keep: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    state_r == st_rd1 && cmd_r.op == op_store_high_byte |=>
      mem_r.wdata == {acc_r[15:8], $past(mem_rdata[7:0])})
    else $error("high byte store wrong");
  chk_word_and: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    state_r == st_rd1 && cmd_r.op == op_and_word |=>
      zf_r == (acc_r == '0) && nf_r == zf_r && acc_r[31:16] == 16'h0000)
    else $error("word and flags wrong");
  chk_stack_and: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    go && cmd.op == op_and_stack |=> acc_r == $past(acc_r & stk_r[0])
      && nf_r == acc_r[31] && zf_r == (acc_r == '0))
    else $error("stack and wrong");
  chk_flag_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    state_r inside {st_rd0, st_rd2} |=> $stable(zf_r) && $stable(nf_r))
    else $error("flag changed early");
  chk_done_soon: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    go |-> ##[1:6] done_r)
    else $error("no done");

  cov_pop: cover property (@(posedge ref_clk) go && cmd.op == op_pop);
  cov_byte: cover property (@(posedge ref_clk)
    go && cmd.op == op_store_high_byte);
  cov_dbl: cover property (@(posedge ref_clk)
    go && cmd.op == op_and_double_word ##[1:5] nf_r);
  cov_field: cover property (@(posedge ref_clk)
    go && cmd.op == op_and_bit_field);
endmodule // accumulator_stack_logic_ops

// ===== word_bit_mem.sv
`include "acc_cfg.svh"
module word_bit_mem
  import acc_pkg::*;
(
  input wire logic ref_clk,
  input acc_pkg::mem_req_t mem_req,
  output logic [`WORD_W-1:0] mem_rdata,
  input acc_pkg::bit_req_t bit_req,
  output logic [`ACC_W-1:0] bit_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:65535];
  logic [2047:0] bits;
  logic [15:0] w_addr_r = '0;
  logic [10:0] b_addr_r = '0;
  logic [1:0] w_hold_r = '0, b_hold_r = '0;
  logic [15:0] w_last_r = '0;
  logic [31:0] b_last_r = '0;
  // data shown from the request cycle for two more; toggles when idle
  always_comb
  begin
    mem_rdata = ~w_last_r;
    if (mem_req.re)
      mem_rdata = mem[mem_req.addr];
    else if (w_hold_r != 2'h0)
      mem_rdata = mem[w_addr_r];
    bit_rdata = ~b_last_r;
    if (bit_req.re)
      bit_rdata = bits[bit_req.addr +: 32];
    else if (b_hold_r != 2'h0)
      bit_rdata = bits[b_addr_r +: 32];
  end
  always @(posedge ref_clk)
  begin
    if (mem_req.we)
      mem[mem_req.addr] <= mem_req.wdata;
    w_last_r <= mem_rdata;
    b_last_r <= bit_rdata;
    if (mem_req.re)
    begin
      w_addr_r <= mem_req.addr;
      w_hold_r <= 2'h2;
    end
    else if (w_hold_r != 2'h0)
      w_hold_r <= w_hold_r - 2'h1;
    if (bit_req.re)
    begin
      b_addr_r <= bit_req.addr;
      b_hold_r <= 2'h2;
    end
    else if (b_hold_r != 2'h0)
      b_hold_r <= b_hold_r - 2'h1;
  end
endmodule // word_bit_mem

// ===== tb_top.sv
`include "acc_cfg.svh"
module tb_top
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_t cmd = '0;
  logic cmd_ready, done, zero_result_flag, negative_result_flag;
  mem_req_t mem_req;
  bit_req_t bit_req;
  logic [15:0] mem_rdata;
  logic [31:0] bit_rdata, acc;
  int err_count = 0;
  int n_tests = 0;

  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  accumulator_stack_logic_ops dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .done(done),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .bit_req(bit_req),
    .bit_rdata(bit_rdata), .acc(acc), .zero_result_flag(zero_result_flag),
    .negative_result_flag(negative_result_flag));

  word_bit_mem mem_u (.ref_clk(ref_clk), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .bit_req(bit_req), .bit_rdata(bit_rdata));

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input logic [1:0] exp);
    n_tests++;
    if ({zero_result_flag, negative_result_flag} !== exp)
    begin
      err_count++;
      $display("Error at %0t: flags %h expected %h", $time,
        {zero_result_flag, negative_result_flag}, exp);
    end
  endtask

  task automatic run_op(input op_t op, input logic [15:0] addr,
    input logic [31:0] imm, input logic [5:0] cnt);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (cmd_ready !== 1'b1)
      chk_val({31'h0, cmd_ready}, 32'h1);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, addr, imm, cnt};
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (done !== 1'b1 && n < 20);
    if (done !== 1'b1)
      chk_val({31'h0, done}, 32'h1);
  endtask

  task automatic test_stack();
    mem_u.mem[16'h20] = 16'h1234;
    mem_u.mem[16'h21] = 16'h8765;
    mem_u.mem[16'h22] = 16'hffff;
    mem_u.mem[16'h23] = 16'hf0f0;
    mem_u.mem[16'h24] = 16'h0f0f;
    mem_u.mem[16'h25] = 16'hff00;
    run_op(op_load_double, 16'h20, '0, '0);
    run_op(op_load_double, 16'h22, '0, '0);
    run_op(op_load_double, 16'h24, '0, '0);
    run_op(op_and_stack, '0, '0, '0);
    chk_val(acc, 32'hf000_0f0f);
    chk_flags(2'b01);
    run_op(op_pop, '0, '0, '0);
    chk_val(acc, 32'h8765_1234);
    chk_flags(2'b01);
    run_op(op_pop, '0, '0, '0);
    chk_val(acc, 32'h0);
    chk_flags(2'b11);
  endtask

  task automatic test_indexed();
    mem_u.mem[16'h26] = 16'h3544;
    mem_u.mem[16'h27] = 16'habcd;
    mem_u.mem[16'h28] = 16'h0015;
    mem_u.mem[16'h29] = 16'h5a5a;
    run_op(op_load_double, 16'h26, '0, '0);
    run_op(op_load_double, 16'h28, '0, '0);
    run_op(op_store_indexed, 16'h0140, '0, '0);
    chk_val({16'h0, mem_u.mem[16'h0155]}, 32'h3544);
    chk_val(acc, 32'h0000_0015);
  endtask

  task automatic test_reset();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    @(negedge ref_clk);
    chk_val(acc, `ACC_RST);
    chk_flags(2'b00);
    chk_val({31'h0, cmd_ready}, 32'h0);
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    run_op(op_pop, '0, '0, '0);
    chk_val(acc, 32'h0);
    chk_flags(2'b10);
  endtask

  task automatic test_bytes_and();
    mem_u.mem[16'h2c] = 16'h7c3d;
    mem_u.mem[16'h2d] = 16'hffff;
    mem_u.mem[16'h30] = 16'ha1b2;
    mem_u.mem[16'h31] = 16'ha1b2;
    mem_u.mem[16'h34] = 16'h0f0f;
    mem_u.mem[16'h35] = 16'h0000;
    run_op(op_load_double, 16'h2c, '0, '0);
    run_op(op_store_low_byte, 16'h30, '0, '0);
    chk_val({16'h0, mem_u.mem[16'h30]}, 32'ha13d);
    run_op(op_store_high_byte, 16'h31, '0, '0);
    chk_val({16'h0, mem_u.mem[16'h31]}, 32'h7cb2);
    run_op(op_and_word, 16'h34, '0, '0);
    chk_val(acc, 32'h0000_0c0d);
    chk_flags(2'b00);
    run_op(op_and_word, 16'h35, '0, '0);
    chk_val(acc, 32'h0);
    chk_flags(2'b11);
  endtask

  task automatic test_and_double();
    mem_u.mem[16'h36] = 16'hffff;
    mem_u.mem[16'h37] = 16'hffff;
    mem_u.mem[16'h38] = 16'h00ff;
    mem_u.mem[16'h39] = 16'h8000;
    run_op(op_load_double, 16'h36, '0, '0);
    run_op(op_and_double_word, 16'h38, '0, '0);
    chk_val(acc, 32'h8000_00ff);
    chk_flags(2'b01);
    run_op(op_and_double_const, '0, 32'h3647_6a38, '0);
    chk_val(acc, 32'h0000_0038);
    chk_flags(2'b00);
    run_op(op_and_double_const, '0, 32'h0, '0);
    chk_flags(2'b10);
  endtask

  task automatic test_bit_field();
    mem_u.bits[16 +: 32] = 32'hfedc_ba9b;
    run_op(op_load_double, 16'h36, '0, '0);
    run_op(op_and_bit_field, 16'h10, '0, 6'h20);
    chk_val(acc, 32'hfedc_ba9b);
    chk_flags(2'b01);
    run_op(op_and_bit_field, 16'h10, '0, 6'h4);
    chk_val(acc, 32'h0000_000b);
    chk_flags(2'b00);
    run_op(op_and_bit_field, 16'h12, '0, 6'h1);
    chk_val(acc, 32'h0);
    chk_flags(2'b10);
  endtask

  task automatic stop_test();
    $display("Checks %0d, errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end

  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    test_stack();
    test_indexed();
    test_reset();
    test_bytes_and();
    test_and_double();
    test_bit_field();
    stop_test();
  end
endmodule // tb_top
